// file: hw/hscs_core.sv
// Purpose: Status assembly and common-practice command handling over APB
// Assumes: pclk 10 MHz, presetn asynchronous active low
// Notes:   Master commands arrive as APB writes; answers read back over APB
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps
module hscs_core (
	input  wire logic              pclk,          // Bus clock
	input  wire logic              presetn,       // Async reset, low active
	input  wire logic              psel,          // APB select
	input  wire logic              penable,       // APB enable
	input  wire logic              pwrite,        // APB direction
	input  wire logic [7:0]        paddr,         // APB byte address
	input  wire logic [31:0]       pwdata,        // APB write data
	output logic      [31:0]       prdata,        // APB read data
	output logic                   pready,        // APB ready
	output logic                   pslverr,       // APB error
	input  wire hscs_pkg::hscs_cond_t cond,       // Live alarm conditions
	input  wire logic [15:0]       flow_raw,      // Linearized scaled flow
	output logic      [15:0]       primary_flow_variable, // Damped flow
	output logic      [15:0]       loop_out,      // Loop current setpoint
	output logic                   fixed_mode,    // Fixed current active
	output logic      [7:0]        summary_status, // Summary status byte
	output logic      [7:0]        ext_status,    // Extended status byte
	output logic      [1:0]        active_proto,  // Protocol in use
	output logic                   irq            // Level interrupt
);
	import hscs_pkg::*;

	// Registers
	hscs_state_t state_r;
	hscs_state_t state_nxt;
	hscs_resp_t  resp_r;
	logic [7:0]  cmd_r;
	logic [15:0] arg_r;
	logic [3:0]  damp_r;
	logic        fixed_r;
	logic [15:0] fixed_val_r;
	logic [1:0]  proto_sel_r;
	logic [1:0]  proto_act_r;
	logic        proto_taken_r;
	logic [7:0]  pre_r;
	logic        cfg_chg_r;
	logic [2:0]  irq_stat_r;
	logic [2:0]  irq_mask_r;
	logic [15:0] flow_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [7:0]  sum_r;
	logic [7:0]  ext_r;
	logic        irq_r;
	logic [15:0] loop_r;

	// Returns one for command numbers in the supported set
	function automatic logic cmd_known(input logic [7:0] c);
		cmd_known = (c == HSCS_C_DAMP) || (c == HSCS_C_RANGE) || (c == HSCS_C_URV)
			|| (c == HSCS_C_LRV) || (c == HSCS_C_CFGCLR) || (c == HSCS_C_FIXED)
			|| (c == HSCS_C_UNITS) || (c == HSCS_C_TRIMLO) || (c == HSCS_C_TRIMHI)
			|| (c == HSCS_C_ADDSTAT) || (c == HSCS_C_PREAMB);
	endfunction

	// Bus phase decode
	wire        acc      = psel && penable && pready_r;
	wire        wr       = acc && pwrite;
	wire        rd       = acc && !pwrite;
	wire        a_cmd    = (paddr == HSCS_CMD_OFF);
	wire        a_resp   = (paddr == HSCS_RESP_OFF);
	wire        a_stat   = (paddr == HSCS_STAT_OFF);
	wire        a_damp   = (paddr == HSCS_DAMP_OFF);
	wire        a_fixed  = (paddr == HSCS_FIXED_OFF);
	wire        a_proto  = (paddr == HSCS_PROTO_OFF);
	wire        a_pre    = (paddr == HSCS_PRE_OFF);
	wire        a_irq    = (paddr == HSCS_IRQ_OFF);
	wire        a_mask   = (paddr == HSCS_MASK_OFF);
	wire        a_flow   = (paddr == HSCS_FLOW_OFF);
	wire        a_loop   = (paddr == HSCS_LOOP_OFF);
	wire        a_any    = a_cmd | a_resp | a_stat | a_damp | a_fixed | a_proto
		| a_pre | a_irq | a_mask | a_flow | a_loop;
	// Command accepted only when idle; polled answers only, never burst
	wire        cmd_go   = wr && a_cmd && (state_r == HSCS_IDLE);

	// Device-specific status bytes track the live conditions
	wire [7:0]  stat_b0  = {cond.param_err, cond.mix_err, cond.sensor_range,
		cond.temp_low, cond.temp_high, cond.flow_low, cond.flow_high,
		cond.power_up};
	wire [7:0]  stat_b1  = {cond.total_err, cond.crc_err, 3'h0, cond.loop_range,
		cond.freq_range, cond.simulation};
	wire        any_fail = |stat_b0 | |stat_b1;
	wire        flow_alert = cond.flow_high | cond.flow_low;
	wire [7:0]  sum_nxt  = (8'(any_fail) << HSCS_MORE_BIT)
		| (8'(cfg_chg_r) << HSCS_CFGCH_BIT);
	wire [7:0]  ext_nxt  = (8'(cond.sensor_range) << HSCS_EXT_MAINT)
		| (8'(flow_alert) << HSCS_EXT_ALERT);

	// Damping: first-order filter, shift set by damping value
	wire [15:0] flow_diff = flow_raw - flow_r;
	wire [15:0] flow_step = (damp_r == HSCS_DAMP_RST) ? flow_diff
		: 16'($signed(flow_diff) >>> damp_r);
	wire [15:0] flow_nxt  = flow_r + flow_step;
	// Loop current follows the damped flow unless held fixed
	wire [15:0] loop_nxt  = fixed_r ? fixed_val_r : flow_r;

	// Command execution decode
	wire        exec      = (state_r == HSCS_EXEC);
	wire        known     = cmd_known(cmd_r);
	wire        is_add    = (cmd_r == HSCS_C_ADDSTAT);
	wire        is_cfgclr = exec && (cmd_r == HSCS_C_CFGCLR);
	wire        is_fix    = exec && (cmd_r == HSCS_C_FIXED);
	wire        is_damp   = exec && (cmd_r == HSCS_C_DAMP);
	wire        is_pre    = exec && (cmd_r == HSCS_C_PREAMB);
	wire        cfg_write = exec && known && !is_add && (cmd_r != HSCS_C_CFGCLR)
		&& (cmd_r != HSCS_C_FIXED);
	wire        sw_write  = wr && (a_damp | a_pre | a_proto);
	wire        resp_rd   = rd && a_resp && (state_r == HSCS_DONE);
	wire [2:0]  irq_ev    = {any_fail, exec && !known, exec};
	wire [2:0]  irq_clr   = (wr && a_irq) ? pwdata[2:0] : 3'h0;

	// Response assembly
	hscs_resp_t resp_nxt;
	assign resp_nxt.code  = known ? HSCS_RC_OK : HSCS_RC_NOTIMPL;
	assign resp_nxt.count = is_add ? HSCS_ADD_BYTES : 2'h0;
	assign resp_nxt.byte0 = is_add ? stat_b0 : 8'h00;
	assign resp_nxt.byte1 = is_add ? stat_b1 : 8'h00;

	// Sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			HSCS_IDLE: if (cmd_go) state_nxt = HSCS_EXEC;
			HSCS_EXEC: state_nxt = HSCS_DONE;
			HSCS_DONE: if (resp_rd) state_nxt = HSCS_IDLE;
			default:   state_nxt = HSCS_IDLE;
		endcase
	end

	// Read mux
	wire [31:0] rd_val =
		a_resp  ? {6'h00, resp_r.count, resp_r.code, resp_r.byte1, resp_r.byte0} :
		a_cmd   ? {29'h0, state_r} :
		a_stat  ? {16'h0, ext_r, sum_r} :
		a_damp  ? {28'h0, damp_r} :
		a_fixed ? {15'h0, fixed_r, fixed_val_r} :
		a_proto ? {28'h0, proto_act_r, proto_sel_r} :
		a_pre   ? {24'h0, pre_r} :
		a_irq   ? {29'h0, irq_stat_r} :
		a_mask  ? {29'h0, irq_mask_r} :
		a_flow  ? {16'h0, flow_r} :
		a_loop  ? {16'h0, loop_r} : 32'h0;

	// Bus answer: no wait state, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end
		else
		begin
			pready_r  <= psel && !penable;
			pslverr_r <= psel && !penable && !a_any;
			prdata_r  <= (psel && !penable && !pwrite) ? rd_val : prdata_r;
		end
	end

	// Command state and answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= HSCS_IDLE;
			cmd_r   <= 8'h00;
			arg_r   <= 16'h0000;
			resp_r  <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			if (cmd_go)
			begin
				cmd_r <= pwdata[7:0];
				arg_r <= pwdata[23:8];
			end
			if (exec)
				resp_r <= resp_nxt;
		end
	end

	// Configuration written by commands or software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			damp_r      <= HSCS_DAMP_RST;
			pre_r       <= HSCS_PRE_RST;
			fixed_r     <= 1'b0;
			fixed_val_r <= 16'h0000;
			cfg_chg_r   <= 1'b0;
			proto_sel_r <= HSCS_PROTO_LOOP;
		end
		else
		begin
			if (is_damp || (wr && a_damp))
				damp_r <= is_damp ? arg_r[3:0] : pwdata[3:0];
			if (is_pre || (wr && a_pre))
				pre_r <= is_pre ? arg_r[7:0] : pwdata[7:0];
			if (is_fix)
			begin
				fixed_r     <= (arg_r != 16'h0000);
				fixed_val_r <= arg_r;
			end
			if (wr && a_proto)
				proto_sel_r <= pwdata[1:0];
			if (cfg_write || sw_write)
				cfg_chg_r <= 1'b1;
			else if (is_cfgclr)
				cfg_chg_r <= 1'b0;
		end
	end

	// Protocol in use latched once after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			proto_act_r   <= HSCS_PROTO_LOOP;
			proto_taken_r <= 1'b0;
		end
		else if (!proto_taken_r)
		begin
			proto_act_r   <= proto_sel_r;
			proto_taken_r <= 1'b1;
		end
	end

	// Status, filter, loop and interrupts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sum_r      <= 8'h00;
			ext_r      <= 8'h00;
			flow_r     <= HSCS_FLOW_RST;
			loop_r     <= 16'h0000;
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
			irq_r      <= 1'b0;
		end
		else
		begin
			sum_r      <= sum_nxt;
			ext_r      <= ext_nxt;
			flow_r     <= flow_nxt;
			loop_r     <= loop_nxt;
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			if (wr && a_mask)
				irq_mask_r <= pwdata[2:0];
			irq_r      <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Outputs from flip-flops
	assign prdata                = prdata_r;
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign primary_flow_variable = flow_r;
	assign loop_out              = loop_r;
	assign fixed_mode            = fixed_r;
	assign summary_status        = sum_r;
	assign ext_status            = ext_r;
	assign active_proto          = proto_act_r;
	assign irq                   = irq_r;
endmodule // hscs_core

// file: hw/hscs_pkg.sv
// Purpose: Constants and types for the loop-protocol status and command block
// Assumes: Single 10 MHz clock, APB register access
// Notes:   Summary of operation list below
//
// Summary of operation
// - Any failure sets more-status bit four
// - Sensor error sets extended device status
// - Flow out of limits sets variable alert
// - Command 48 answers two status bytes
// - Status bits follow conditions, self clearing
// - Byte 0 bits 0-4: power-up, limits
// - Byte 0 bits 5-7: sensor, mix, parameters
// - Byte 1: simulation, outputs, CRC, total
// - Common-practice commands 34..59 listed set accepted
// - Command 38 clears configuration-changed flag
// - No burst; answer only when polled
// - Catch device variable not supported
// - No device-specific commands recognised
// - Command 40 fixed current; reset leaves it
// - Damping only on flow and loop current
// - Protocol change applies after power cycle; here reset also returns the selection to loop, so loop stays active
// - Reported flow variable drives loop current
package hscs_pkg;
	// Register byte offsets
	localparam logic [7:0] HSCS_CMD_OFF    = 8'h00;
	localparam logic [7:0] HSCS_RESP_OFF   = 8'h04;
	localparam logic [7:0] HSCS_STAT_OFF   = 8'h08;
	localparam logic [7:0] HSCS_DAMP_OFF   = 8'h0C;
	localparam logic [7:0] HSCS_FIXED_OFF  = 8'h10;
	localparam logic [7:0] HSCS_PROTO_OFF  = 8'h14;
	localparam logic [7:0] HSCS_PRE_OFF    = 8'h18;
	localparam logic [7:0] HSCS_IRQ_OFF    = 8'h1C;
	localparam logic [7:0] HSCS_MASK_OFF   = 8'h20;
	localparam logic [7:0] HSCS_FLOW_OFF   = 8'h24;
	localparam logic [7:0] HSCS_LOOP_OFF   = 8'h28;
	// Command numbers
	localparam logic [7:0] HSCS_C_DAMP     = 8'h22;
	localparam logic [7:0] HSCS_C_RANGE    = 8'h23;
	localparam logic [7:0] HSCS_C_URV      = 8'h24;
	localparam logic [7:0] HSCS_C_LRV      = 8'h25;
	localparam logic [7:0] HSCS_C_CFGCLR   = 8'h26;
	localparam logic [7:0] HSCS_C_FIXED    = 8'h28;
	localparam logic [7:0] HSCS_C_UNITS    = 8'h2C;
	localparam logic [7:0] HSCS_C_TRIMLO   = 8'h2D;
	localparam logic [7:0] HSCS_C_TRIMHI   = 8'h2E;
	localparam logic [7:0] HSCS_C_ADDSTAT  = 8'h30;
	localparam logic [7:0] HSCS_C_PREAMB   = 8'h3B;
	// Response codes and counts
	localparam logic [7:0] HSCS_RC_OK      = 8'h00;
	localparam logic [7:0] HSCS_RC_NOTIMPL = 8'h40;
	localparam logic [1:0] HSCS_ADD_BYTES  = 2'h2;
	// Summary status bit positions
	localparam int HSCS_MORE_BIT  = 4;
	localparam int HSCS_CFGCH_BIT = 6;
	// Extended status bit positions
	localparam int HSCS_EXT_MAINT = 0;
	localparam int HSCS_EXT_ALERT = 1;
	// Reset values
	localparam logic [3:0]  HSCS_DAMP_RST  = 4'h0;
	localparam logic [7:0]  HSCS_PRE_RST   = 8'h05;
	localparam logic [15:0] HSCS_FLOW_RST  = 16'h0000;
	// Interrupt event bit positions
	localparam int HSCS_IRQ_DONE  = 0;
	localparam int HSCS_IRQ_NOTIM = 1;
	localparam int HSCS_IRQ_FAIL  = 2;
	// Protocol selection code
	localparam logic [1:0]  HSCS_PROTO_LOOP = 2'h0;

	// Raw alarm and error conditions from the measurement side
	typedef struct packed {
		logic total_err;
		logic crc_err;
		logic loop_range;
		logic freq_range;
		logic simulation;
		logic param_err;
		logic mix_err;
		logic sensor_range;
		logic temp_low;
		logic temp_high;
		logic flow_low;
		logic flow_high;
		logic power_up;
	} hscs_cond_t;

	// Command answer as seen by software
	typedef struct packed {
		logic [7:0] code;
		logic [1:0] count;
		logic [7:0] byte0;
		logic [7:0] byte1;
	} hscs_resp_t;

	typedef enum logic [2:0] {
		HSCS_IDLE = 3'b001,
		HSCS_EXEC = 3'b010,
		HSCS_DONE = 3'b100
	} hscs_state_t;
endpackage

// file: test/hscs_master.sv
// Purpose: APB master standing in for the loop host
// Assumes: One transfer at a time
// Notes:   Waits on pready; only the bench timeout ends a hang
`timescale 1ns/10ps
module hscs_master (
	input  wire logic        pclk,    // Clock
	input  wire logic        pready,  // Slave ready
	input  wire logic [31:0] prdata,  // Read data
	input  wire logic        pslverr, // Slave error
	output logic             psel,    // Select
	output logic             penable, // Enable
	output logic             pwrite,  // Direction
	output logic [7:0]       paddr,   // Address
	output logic [31:0]      pwdata   // Write data
);
	// Idle bus at time zero
	initial
		{psel, penable, pwrite, paddr, pwdata} = '0;
	// One transfer: setup, then access until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule // hscs_master

// file: test/hscs_sva.sv
// Purpose: Port-level checks for the status and command block
// Assumes: Single clock, presetn async active low
// Notes:   Bound onto every instance of the core
`timescale 1ns/10ps
module hscs_sva
	import hscs_pkg::*;
(
	input wire logic        pclk,                  // Clock
	input wire logic        presetn,               // Reset, low active
	input wire logic        psel,                  // APB select
	input wire logic        penable,               // APB enable
	input wire logic        pwrite,                // APB direction
	input wire logic [7:0]  paddr,                 // APB address
	input wire logic [31:0] prdata,                // APB read data
	input wire logic        pready,                // APB ready
	input wire logic        pslverr,               // APB error
	input wire hscs_pkg::hscs_cond_t cond,         // Live conditions
	input wire logic [15:0] primary_flow_variable, // Damped flow
	input wire logic [15:0] loop_out,              // Loop setpoint
	input wire logic        fixed_mode,            // Fixed current
	input wire logic [7:0]  summary_status,        // Summary byte
	input wire logic [7:0]  ext_status,            // Extended byte
	input wire logic [1:0]  active_proto           // Protocol in use
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup phase of a transfer
	sequence s_setup;
		psel && !penable;
	endsequence
	property p_more;
		##1 summary_status[HSCS_MORE_BIT] == $past(|cond);
	endproperty
	a_more: assert property (p_more) else $error("more status bit wrong");
	property p_sensor;
		##1 ext_status[HSCS_EXT_MAINT] == $past(cond.sensor_range);
	endproperty
	a_sensor: assert property (p_sensor) else $error("sensor bit wrong");
	property p_alert;
		##1 ext_status[HSCS_EXT_ALERT] == $past(cond.flow_high || cond.flow_low);
	endproperty
	a_alert: assert property (p_alert) else $error("alert bit wrong");
	property p_ready;
		s_setup |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready late");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err;
		pready && paddr > 8'h28 |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_ok;
		pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped refused");
	property p_loop;
		(!fixed_mode && $stable(primary_flow_variable)) [*3] |-> loop_out == primary_flow_variable;
	endproperty
	a_loop: assert property (p_loop) else $error("loop not flow");
	property p_proto;
		$past(presetn) |-> $stable(active_proto);
	endproperty
	a_proto: assert property (p_proto) else $error("protocol changed");
endmodule // hscs_sva

bind hscs_core hscs_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .cond, .primary_flow_variable, .loop_out, .fixed_mode,
	.summary_status, .ext_status, .active_proto);

// file: test/tb_hart_status_and_command_set.sv
// Purpose: Self-checking bench for the status and command block
// Assumes: 10 MHz clock, reset held 8 cycles
// Notes:   Expected values come from a small model here
`timescale 1ns/10ps
module tb_hart_status_and_command_set;
	import hscs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fixed_mode, irq, e;
	logic [7:0]  paddr, summary_status, ext_status;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] flow_raw, primary_flow_variable, loop_out, arg;
	logic [1:0]  active_proto;
	hscs_cond_t  cond;
	int          error_cnt, checks, cyc, i, seed;
	int          sup[$] = '{34, 35, 36, 37, 38, 40, 44, 45, 46, 59};
	int          tbl[$] = '{34, 35, 36, 37, 38, 40, 44, 45, 46, 59, 33, 39, 47, 60, 128, 255};
	hscs_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cond, .flow_raw, .primary_flow_variable, .loop_out, .fixed_mode,
		.summary_status, .ext_status, .active_proto, .irq);
	hscs_master m_u (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	always #50 pclk = ~pclk;
	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Issue one command, wait three cycles, fetch answer
	task automatic cmd(input logic [7:0] c, input logic [15:0] a);
		m_u.xfer(1'b1, HSCS_CMD_OFF, {8'h00, a, c}, q, e);
		repeat (3) @(posedge pclk);
		m_u.xfer(1'b0, HSCS_RESP_OFF, 32'h0, q, e);
	endtask
	// Model: count and code of an answer
	function automatic logic [9:0] exp_code(input int c);
		if (c == 48)
			return 10'h200;
		foreach (sup[k])
			if (sup[k] == c)
				return 10'h000;
		return 10'h040;
	endfunction
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	initial
	begin
		{pclk, presetn, error_cnt, checks, cyc} = '0;
		{cond, flow_raw} = '0;
		seed = 32'h5b6483a1;
		do_reset();
		// Random conditions, then all clear
		for (i = 0; i < 12; i++)
		begin
			cond <= (i == 11) ? '0 : 13'($random(seed));
			repeat (2) @(posedge pclk);
			chk("more", 32'(|cond), summary_status[4]);
			chk("ext", {cond.flow_high | cond.flow_low, cond.sensor_range}, ext_status[1:0]);
			cmd(HSCS_C_ADDSTAT, 16'h0);
			chk("status", {6'h0, 2'h2, 8'h0, cond[12:11], 3'h0, cond[10:0]}, q[25:0]);
		end
		// Every listed command except 48, and some unlisted commands
		foreach (tbl[j])
		begin
			cmd(8'(tbl[j]), 16'h0);
			chk("code", exp_code(tbl[j]), q[25:16]);
		end
		// Flag cleared first so that the set below is seen
		cmd(HSCS_C_CFGCLR, 16'h0);
		chk("cfg clr first", 0, summary_status[HSCS_CFGCH_BIT]);
		cmd(HSCS_C_DAMP, 16'h0003);
		chk("cfg set", 1, summary_status[HSCS_CFGCH_BIT]);
		m_u.xfer(1'b0, HSCS_DAMP_OFF, 32'h0, q, e);
		chk("damp", 32'h3, q);
		cmd(HSCS_C_PREAMB, 16'h0007);
		m_u.xfer(1'b0, HSCS_PRE_OFF, 32'h0, q, e);
		chk("preambles", 32'h7, q);
		cmd(HSCS_C_CFGCLR, 16'h0);
		chk("cfg clr", 0, summary_status[HSCS_CFGCH_BIT]);
		// Protocol select is stored but the active one stays
		m_u.xfer(1'b1, HSCS_PROTO_OFF, 32'h1, q, e);
		m_u.xfer(1'b0, HSCS_PROTO_OFF, 32'h0, q, e);
		chk("proto", 32'h1, q);
		chk("proto act", 0, active_proto);
		// Fixed current enter, exit, and loss by reset
		arg = 16'($random(seed)) | 16'h0001;
		cmd(HSCS_C_FIXED, arg);
		chk("fixed", {1'b1, arg}, {fixed_mode, loop_out});
		cmd(HSCS_C_FIXED, 16'h0);
		chk("unfixed", 0, fixed_mode);
		cmd(HSCS_C_FIXED, 16'hFFFF);
		do_reset();
		chk("fixed reset", 0, fixed_mode);
		// Undamped flow reaches variable and loop
		flow_raw <= 16'($random(seed));
		repeat (20) @(posedge pclk);
		chk("flow", {flow_raw, flow_raw}, {primary_flow_variable, loop_out});
		// Unmapped read is refused
		m_u.xfer(1'b0, 8'h40, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		// Interrupt raise, mask, clear
		m_u.xfer(1'b1, HSCS_IRQ_OFF, 32'h7, q, e);
		m_u.xfer(1'b1, HSCS_MASK_OFF, 32'h2, q, e);
		cmd(8'h21, 16'h0);
		repeat (2) @(posedge pclk);
		chk("irq", 1, irq);
		m_u.xfer(1'b1, HSCS_IRQ_OFF, 32'h2, q, e);
		repeat (2) @(posedge pclk);
		chk("irq clr", 0, irq);
		summarize();
	end
endmodule // tb_hart_status_and_command_set
